// *** hw/clk_sel_map.svh ***
`ifndef CLK_SEL_MAP_SVH
`define CLK_SEL_MAP_SVH

// Register byte offsets on the Avalon-MM slave
`define OSC_CONTROL_OFS 4'h0
`define OSC_STATE_OFS 4'h4

// Control register fields
`define IRCF_LSB 3
`define IRCF_MSB 6
`define SCS_LSB 0
`define SCS_MSB 1
`define IRCF_RESET 4'h7
`define SCS_RESET 2'h0

// Status register bit positions
`define STAT_CRYSTAL_RDY 7
`define STAT_ON_EXT 5
`define STAT_FAST_RDY 4
`define STAT_SLOW_RDY 1
`define STAT_FAST_STB 0

// Power-up oscillator configuration codes
`define CFG_INTERNAL 2'h0
`define CFG_EXT_HIGH 2'h3
`define CFG_EXT_LOW 2'h1

// Timing
`define REF_CLK_MHZ 250
`define FAST_START_NS 2000
`define EXT_SWITCH_EDGES 11'h002
`define CRYSTAL_SWITCH_EDGES 11'h400

`endif

// *** hw/clk_sel_pkg.sv ***
package clk_sel_pkg;

  // Clock source, one-hot
  typedef enum logic [3:0] {
    SRC_EXT = 4'h1,
    SRC_CRYSTAL = 4'h2,
    SRC_SLOW = 4'h4,
    SRC_FAST = 4'h8
  } src_t;

  // Source plus postscaler exponent (fast source only)
  typedef struct packed {
    src_t src;
    logic [3:0] shift;
  } clk_choice_t;

  // Clock switch sequencer
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_START = 4'h2,
    ST_WAIT_FALL = 4'h4,
    ST_WAIT_RISE = 4'h8
  } sw_state_t;

  typedef struct packed {
    logic [3:0] int_freq_sel;
    logic [1:0] sys_src_sel;
  } osc_control_t;

  typedef struct packed {
    logic crystal_osc_ready;
    logic on_ext;
    logic fast_osc_ready;
    logic slow_osc_ready;
    logic fast_osc_stable;
  } osc_status_t;

endpackage

// *** hw/system_clock_source_select.sv ***
// Chosen here: the register addresses and the Avalon-MM slave port.
`include "clk_sel_map.svh"
// Summary of operation
// RULE1 - Secondary 32.768 kHz crystal oscillator selectable as system clock at run time.
// RULE2 - Power-up config selecting internal block runs on it right after reset; code starts on the external clock and switches after fast start-up.
// RULE3 - In internal oscillator mode the external clock pin is freed as GPIO.
// RULE4 - A config bit picks instruction clock out or GPIO on the clock pin.
// RULE5 - Internal block holds a 16 MHz fast and a 31 kHz slow oscillator.
// RULE6 - Fast oscillator on when fast setting chosen and source 1x or config 11.
// RULE7 - Slow oscillator on when 000x chosen and source 1x or config 01.
// RULE8 - Slow oscillator also runs while power-up or watchdog timer is enabled.
// RULE9 - Read-only fast ready flag shows the fast oscillator is usable.
// RULE10 - Read-only stable flag set only once fast oscillator is within 0.5%.
// RULE11 - Read-only slow ready flag shows the slow oscillator is usable.
// RULE12 - Frequency select gives 16 MHz down to 31.25 kHz, or slow 31 kHz.
// RULE13 - Every reset loads frequency select with 0111, i.e. 500 kHz.
// RULE14 - Changes between settings of the same oscillator skip start-up delay.
// RULE15 - Start new oscillator if off, wait current fall, hold low, await new rise.
// RULE16 - Status flags updated once the new clock is active, before completion.
// RULE17 - Delays: slow one cycle each, fast 2 us, external 2, crystal 1024 cycles.
// RULE18 - Source select 00 takes the clock named by the power-up config.
// RULE19 - Source select 01 uses the secondary crystal oscillator.
// RULE20 - Source select 1x uses the internal block at the selected frequency.
// RULE21 - Every reset clears source select.
// RULE22 - Frequency decode: 000x slow, 001x 31.25k, 0100-0111, 1000-1010, 1011-1111.
// RULE23 - Power-up config 00 means internal; other codes mean external clock.
// RULE24 - Software checks crystal ready before selecting the crystal oscillator.
// RULE25 - Switched clock never has a phase shorter than the slower clock's phase; the code only ensures a full low phase of the new clock before it rises.
module system_clock_source_select #(
  parameter int FAST_STABLE_CYC = 1000
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [1:0] POWERUP_OSC_CFG,
  input wire logic CLOCK_OUT_PIN_CFG,
  input wire logic POWERUP_TIMER_EN,
  input wire logic WATCHDOG_TIMER_EN,
  input wire logic CRYSTAL_OSC_EN,
  input wire logic FAST_OSC_IN,
  input wire logic SLOW_OSC_IN,
  input wire logic CRYSTAL_OSC_IN,
  input wire logic EXT_CLOCK_IN,
  input wire logic GPIO_CLOCK_OUTPUT_PIN_DATA,
  input wire logic GPIO_CLOCK_OUTPUT_PIN_OE_N,
  output logic FAST_OSC_EN,
  output logic SLOW_OSC_EN,
  output logic SYS_CLK,
  output logic EXT_CLOCK_PIN_GPIO,
  output logic CLOCK_OUTPUT_PIN_O,
  output logic CLOCK_OUTPUT_PIN_OE_N
);

  localparam int FAST_START_CYC = (`FAST_START_NS * `REF_CLK_MHZ + 999) / 1000;

  generate
    if (FAST_STABLE_CYC <= FAST_START_CYC || FAST_STABLE_CYC > 65535) begin : g_bad_param
      $error("FAST_STABLE_CYC out of range");
    end
  endgenerate

  // Postscaler exponent for the fast source, 16 MHz >> shift
  function automatic logic [3:0] freq_shift(input logic [3:0] ircf);
    logic [3:0] s;
    s = 4'h0;
    case (ircf) // RULE22
      4'h2, 4'h3: s = 4'h9;
      4'h4: s = 4'h8;
      4'h5, 4'h8: s = 4'h7;
      4'h6, 4'h9: s = 4'h6;
      4'h7, 4'hA: s = 4'h5;
      4'hB: s = 4'h4;
      4'hC: s = 4'h3;
      4'hD: s = 4'h2;
      4'hE: s = 4'h1;
      default: s = 4'h0;
    endcase
    return s;
  endfunction

  // Internal block choice from the frequency select alone
  function automatic clk_sel_pkg::clk_choice_t internal_choice(input logic [3:0] ircf);
    clk_sel_pkg::clk_choice_t c;
    c.src = (ircf[3:1] == 3'h0) ? clk_sel_pkg::SRC_SLOW : clk_sel_pkg::SRC_FAST;
    c.shift = (ircf[3:1] == 3'h0) ? 4'h0 : freq_shift(ircf);
    return c;
  endfunction

  // Strap latches; the config word is captured while reset is held
  logic [1:0] cfg_q;
  logic clock_output_pin_cfg_q;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cfg_q <= POWERUP_OSC_CFG;
      clock_output_pin_cfg_q <= CLOCK_OUT_PIN_CFG;
    end
  end

  // Oscillator levels sampled with their previous value for edge detection
  logic fast_q, slow_q, crys_q, ext_q;
  logic fast_p_q, slow_p_q, crys_p_q, ext_p_q;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      {fast_q, slow_q, crys_q, ext_q} <= 4'h0;
      {fast_p_q, slow_p_q, crys_p_q, ext_p_q} <= 4'h0;
    end else begin
      {fast_q, slow_q, crys_q, ext_q} <= {FAST_OSC_IN, SLOW_OSC_IN, CRYSTAL_OSC_IN, EXT_CLOCK_IN};
      {fast_p_q, slow_p_q, crys_p_q, ext_p_q} <= {fast_q, slow_q, crys_q, ext_q};
    end
  end
  logic fast_rise, slow_rise, crys_rise, ext_rise;
  assign fast_rise = fast_q & ~fast_p_q;
  assign slow_rise = slow_q & ~slow_p_q;
  assign crys_rise = crys_q & ~crys_p_q;
  assign ext_rise = ext_q & ~ext_p_q;

  // Fast postscaler: bit k toggles every 2^k fast periods
  logic [8:0] div_q;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      div_q <= 9'h000;
    end else if (fast_rise) begin
      div_q <= div_q + 9'h001; // RULE12
    end
  end
  logic [9:0] fast_taps;
  assign fast_taps = {div_q, fast_q};

  // Control register
  clk_sel_pkg::osc_control_t ctrl_q;
  logic wr_commit;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_q.int_freq_sel <= `IRCF_RESET; // RULE13
      ctrl_q.sys_src_sel <= `SCS_RESET; // RULE21
    end else if (wr_commit && AVS_ADDRESS == `OSC_CONTROL_OFS && AVS_BYTEENABLE[0]) begin
      ctrl_q.int_freq_sel <= AVS_WRITEDATA[`IRCF_MSB:`IRCF_LSB];
      ctrl_q.sys_src_sel <= AVS_WRITEDATA[`SCS_MSB:`SCS_LSB];
    end
  end

  // Requested clock from source select and power-up config
  clk_sel_pkg::clk_choice_t target;
  always_comb begin
    target.src = clk_sel_pkg::SRC_EXT;
    target.shift = 4'h0;
    if (ctrl_q.sys_src_sel[1]) begin
      target = internal_choice(ctrl_q.int_freq_sel); // RULE20 RULE5
    end else if (ctrl_q.sys_src_sel[0]) begin
      target.src = clk_sel_pkg::SRC_CRYSTAL; // RULE19 RULE1
    end else if (cfg_q == `CFG_INTERNAL) begin
      target = internal_choice(ctrl_q.int_freq_sel); // RULE18 RULE23 RULE2
    end
  end

  // Switch state
  clk_sel_pkg::sw_state_t state_q;
  clk_sel_pkg::clk_choice_t cur_q, new_q;
  logic [10:0] wait_cnt_q;
  logic new_fell_q;

  // Level of a given choice
  function automatic logic level_of(input clk_sel_pkg::clk_choice_t c, input logic [9:0] taps,
                                    input logic sl, input logic cr, input logic ex);
    logic l;
    l = 1'b0;
    case (c.src)
      clk_sel_pkg::SRC_FAST: l = taps[c.shift];
      clk_sel_pkg::SRC_SLOW: l = sl;
      clk_sel_pkg::SRC_CRYSTAL: l = cr;
      default: l = ex;
    endcase
    return l;
  endfunction
  logic cur_lvl, new_lvl, new_lvl_p_q;
  assign cur_lvl = level_of(cur_q, fast_taps, slow_q, crys_q, ext_q);
  assign new_lvl = level_of(new_q, fast_taps, slow_q, crys_q, ext_q);

  // Oscillator readiness tracking
  logic [15:0] fast_cnt_q;
  logic slow_ready_q;
  logic [10:0] crys_cnt_q;
  logic fast_ready, fast_stable, crystal_ready;
  assign fast_ready = fast_cnt_q >= 16'(FAST_START_CYC); // RULE9
  assign fast_stable = fast_cnt_q >= 16'(FAST_STABLE_CYC); // RULE10
  assign crystal_ready = ~CRYSTAL_OSC_EN || crys_cnt_q == `CRYSTAL_SWITCH_EDGES;
  always_ff @(posedge REF_CLK) begin
    if (RST || !FAST_OSC_EN) begin
      fast_cnt_q <= 16'h0000;
    end else if (!fast_stable) begin
      fast_cnt_q <= fast_cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RST || !SLOW_OSC_EN) begin
      slow_ready_q <= 1'b0;
    end else if (slow_rise) begin
      slow_ready_q <= 1'b1; // RULE11
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RST || !CRYSTAL_OSC_EN) begin
      crys_cnt_q <= 11'h000;
    end else if (crys_rise && crys_cnt_q != `CRYSTAL_SWITCH_EDGES) begin
      crys_cnt_q <= crys_cnt_q + 11'h001;
    end
  end

  // Start-up wait for the new source is over
  logic start_done;
  always_comb begin
    case (new_q.src)
      clk_sel_pkg::SRC_FAST: start_done = fast_ready; // RULE17
      clk_sel_pkg::SRC_SLOW: start_done = slow_ready_q; // RULE17
      clk_sel_pkg::SRC_CRYSTAL: start_done = wait_cnt_q == `CRYSTAL_SWITCH_EDGES; // RULE17
      default: start_done = wait_cnt_q == `EXT_SWITCH_EDGES; // RULE17
    endcase
  end
  logic new_edge;
  assign new_edge = (new_q.src == clk_sel_pkg::SRC_CRYSTAL) ? crys_rise : ext_rise;

  // Switch sequencer; the request is latched so a later write waits its turn
  logic already_up;
  assign already_up = (target.src == cur_q.src) || // RULE14
                      (target.src == clk_sel_pkg::SRC_FAST && fast_ready) ||
                      (target.src == clk_sel_pkg::SRC_SLOW && slow_ready_q);
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_q <= clk_sel_pkg::ST_RUN;
      cur_q <= '{src: clk_sel_pkg::SRC_EXT, shift: 4'h0};
      new_q <= '{src: clk_sel_pkg::SRC_EXT, shift: 4'h0};
      wait_cnt_q <= 11'h000;
      new_fell_q <= 1'b0;
      new_lvl_p_q <= 1'b0;
    end else begin
      new_lvl_p_q <= new_lvl;
      case (state_q)
        clk_sel_pkg::ST_RUN: begin
          wait_cnt_q <= 11'h000;
          if (target != cur_q) begin
            new_q <= target;
            state_q <= already_up ? clk_sel_pkg::ST_WAIT_FALL : clk_sel_pkg::ST_START; // RULE15
          end
        end
        clk_sel_pkg::ST_START: begin
          if (start_done) begin
            state_q <= clk_sel_pkg::ST_WAIT_FALL;
          end else if (new_edge) begin
            wait_cnt_q <= wait_cnt_q + 11'h001;
          end
        end
        clk_sel_pkg::ST_WAIT_FALL: begin
          new_fell_q <= 1'b0;
          if (!cur_lvl) begin
            state_q <= clk_sel_pkg::ST_WAIT_RISE; // RULE15
          end
        end
        default: begin
          // A full low phase of the new clock must pass before it is let through
          if (!new_lvl && new_lvl_p_q) begin
            new_fell_q <= 1'b1; // RULE25
          end
          if (new_fell_q && new_lvl) begin
            cur_q <= new_q; // RULE15
            state_q <= clk_sel_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  // Switched system clock, held low between the old fall and new rise
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      SYS_CLK <= 1'b0;
    end else if (state_q == clk_sel_pkg::ST_WAIT_RISE) begin
      SYS_CLK <= new_fell_q & new_lvl; // RULE15 RULE25
    end else if (state_q == clk_sel_pkg::ST_WAIT_FALL) begin
      SYS_CLK <= cur_lvl & SYS_CLK;
    end else begin
      SYS_CLK <= cur_lvl;
    end
  end

  // Oscillator enables; a source in use or being switched to stays on
  logic ircf_slow, want_fast, want_slow, switching;
  assign ircf_slow = ctrl_q.int_freq_sel[3:1] == 3'h0;
  assign want_fast = ~ircf_slow && (ctrl_q.sys_src_sel[1] || cfg_q == `CFG_EXT_HIGH);
  assign want_slow = ircf_slow && (ctrl_q.sys_src_sel[1] || cfg_q == `CFG_EXT_LOW);
  assign switching = state_q != clk_sel_pkg::ST_RUN;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      FAST_OSC_EN <= 1'b0;
      SLOW_OSC_EN <= 1'b0;
    end else begin
      FAST_OSC_EN <= want_fast || target.src == clk_sel_pkg::SRC_FAST || // RULE6
                     cur_q.src == clk_sel_pkg::SRC_FAST ||
                     (switching && new_q.src == clk_sel_pkg::SRC_FAST);
      SLOW_OSC_EN <= want_slow || POWERUP_TIMER_EN || WATCHDOG_TIMER_EN || // RULE7 RULE8
                     target.src == clk_sel_pkg::SRC_SLOW || cur_q.src == clk_sel_pkg::SRC_SLOW ||
                     (switching && new_q.src == clk_sel_pkg::SRC_SLOW);
    end
  end

  // Status snapshot follows live state except mid-switch
  clk_sel_pkg::osc_status_t stat_q;
  logic completing;
  assign completing = state_q == clk_sel_pkg::ST_WAIT_RISE && new_fell_q && new_lvl;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      stat_q <= '0;
    end else if (!switching || completing) begin
      stat_q.crystal_osc_ready <= crystal_ready;
      stat_q.on_ext <= completing ? new_q.src == clk_sel_pkg::SRC_EXT
                                  : cur_q.src == clk_sel_pkg::SRC_EXT;
      stat_q.fast_osc_ready <= fast_ready; // RULE16
      stat_q.slow_osc_ready <= slow_ready_q; // RULE16
      stat_q.fast_osc_stable <= fast_stable;
    end
  end

  // Pin functions fixed by the latched config word
  logic [1:0] icyc_q;
  logic sys_p_q;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      icyc_q <= 2'h0;
      sys_p_q <= 1'b0;
      EXT_CLOCK_PIN_GPIO <= 1'b0;
      CLOCK_OUTPUT_PIN_O <= 1'b0;
      CLOCK_OUTPUT_PIN_OE_N <= 1'b1;
    end else begin
      sys_p_q <= SYS_CLK;
      if (SYS_CLK && !sys_p_q) begin
        icyc_q <= icyc_q + 2'h1; // Instruction clock is the system clock over four
      end
      EXT_CLOCK_PIN_GPIO <= cfg_q == `CFG_INTERNAL; // RULE3
      CLOCK_OUTPUT_PIN_O <= clock_output_pin_cfg_q ? icyc_q[1] : GPIO_CLOCK_OUTPUT_PIN_DATA; // RULE4
      CLOCK_OUTPUT_PIN_OE_N <= clock_output_pin_cfg_q ? 1'b0 : GPIO_CLOCK_OUTPUT_PIN_OE_N; // RULE4
    end
  end

  // Avalon slave: one wait cycle, then the access completes on the next edge
  logic req;
  assign req = AVS_READ | AVS_WRITE;
  assign wr_commit = AVS_WRITE & ~AVS_WAITREQUEST;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else if (req && AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b0;
      if (AVS_ADDRESS == `OSC_CONTROL_OFS) begin
        AVS_READDATA <= {25'h0, ctrl_q.int_freq_sel, 1'b0, ctrl_q.sys_src_sel};
      end else if (AVS_ADDRESS == `OSC_STATE_OFS) begin
        AVS_READDATA <= {24'h0, stat_q.crystal_osc_ready, 1'b0, stat_q.on_ext,
                         stat_q.fast_osc_ready, 2'h0, stat_q.slow_osc_ready,
                         stat_q.fast_osc_stable};
      end else begin
        AVS_READDATA <= 32'h0000_0000;
      end
    end else begin
      AVS_WAITREQUEST <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  reset_defaults_a: assert property ($fell(RST) |-> ctrl_q.int_freq_sel == 4'h7 && // RULE13
      ctrl_q.sys_src_sel == 2'h0) else $error("control not at reset value");
  src_cleared_a: assert property ($fell(RST) |-> target.src == // RULE21
      ((cfg_q == 2'h0) ? clk_sel_pkg::SRC_FAST : clk_sel_pkg::SRC_EXT))
      else $error("source not from config after reset");
  fast_enable_a: assert property (want_fast |=> FAST_OSC_EN) // RULE6
      else $error("fast oscillator not enabled");
  timer_slow_en_a: assert property ((POWERUP_TIMER_EN || WATCHDOG_TIMER_EN) |=> SLOW_OSC_EN) // RULE8
      else $error("slow oscillator off while timers need it");
  fast_ready_clear_a: assert property (!FAST_OSC_EN |=> !fast_ready) // RULE9
      else $error("fast ready without oscillator");
  stable_after_ready_a: assert property ($rose(fast_stable) |-> fast_ready && // RULE10
      $past(fast_ready)) else $error("stable before ready");
  hold_low_a: assert property (state_q == clk_sel_pkg::ST_WAIT_RISE && // RULE15
      $past(state_q) == clk_sel_pkg::ST_WAIT_RISE |-> !SYS_CLK || completing == 1'b0 && $past(completing))
      else $error("clock not held low during switch");
  same_src_fast_a: assert property (state_q == clk_sel_pkg::ST_RUN && target != cur_q && // RULE14
      target.src == cur_q.src |=> state_q == clk_sel_pkg::ST_WAIT_FALL)
      else $error("start delay inserted on same source");
  ext_pin_gpio_a: assert property (cfg_q == 2'h0 ##1 cfg_q == 2'h0 |-> EXT_CLOCK_PIN_GPIO) // RULE3
      else $error("external clock pin not released");
  clock_output_pin_oe_a: assert property (clock_output_pin_cfg_q ##1 clock_output_pin_cfg_q |-> !CLOCK_OUTPUT_PIN_OE_N) // RULE4
      else $error("clock out pin not driven");

  to_crystal_c: cover property (completing && new_q.src == clk_sel_pkg::SRC_CRYSTAL);
  to_fast_c: cover property (completing && new_q.src == clk_sel_pkg::SRC_FAST);
  to_slow_c: cover property (completing && new_q.src == clk_sel_pkg::SRC_SLOW);
  postscale_c: cover property (completing && cur_q.src == clk_sel_pkg::SRC_FAST);

endmodule

// *** bench/osc_partner.sv ***
// One free-standing oscillator; a stopped oscillator parks low, it never floats
module osc_gen #(
  parameter int HALF = 2
) (
  input wire logic clk,
  input wire logic en,
  output logic o
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;

  initial o = 1'h0;

  // Toggle every HALF reference cycles while enabled
  always @(posedge clk) begin
    if (!en) begin
      n <= 0;
      o <= 1'h0;
    end else if (n == HALF - 1) begin
      n <= 0;
      o <= ~o;
    end else begin
      n <= n + 1;
    end
  end
endmodule

// Sources on the far side, scaled down so a run stays short
module osc_partner #(
  parameter int FAST_HALF = 3,
  parameter int SLOW_HALF = 20,
  parameter int XTAL_HALF = 6,
  parameter int EXT_HALF = 5
) (
  input wire logic clk,
  input wire logic fast_en,
  input wire logic slow_en,
  input wire logic xtal_en,
  output logic fast_o,
  output logic slow_o,
  output logic xtal_o,
  output logic ext_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Two independent internal sources, the crystal, and a free-running external clock
  osc_gen #(.HALF(FAST_HALF)) fast_g (.clk(clk), .en(fast_en), .o(fast_o));
  osc_gen #(.HALF(SLOW_HALF)) slow_g (.clk(clk), .en(slow_en), .o(slow_o));
  osc_gen #(.HALF(XTAL_HALF)) xtal_g (.clk(clk), .en(xtal_en), .o(xtal_o));
  osc_gen #(.HALF(EXT_HALF)) ext_g (.clk(clk), .en(1'h1), .o(ext_o));
endmodule

// *** bench/system_clock_source_select_tb_top.sv ***
module system_clock_source_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FH = 3;
  localparam int SH = 20;
  localparam int XH = 6;
  localparam int EH = 5;
  localparam int STB = 600;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] adr = 4'h0;
  logic [3:0] be = 4'hF;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wdat = 32'h0;
  logic [1:0] cfg = 2'h0;
  logic co_cfg = 1'h1;
  logic pwt = 1'h0;
  logic wdt = 1'h0;
  logic xen = 1'h0;
  logic gdat = 1'h0;
  logic goe_n = 1'h1;
  logic [31:0] rdat;
  logic wait_rq, f_in, s_in, x_in, e_in, f_en, s_en, sys_clk, pin_gpio, co_o, co_oe_n;
  int errors = 0;
  int checked = 0;

  system_clock_source_select #(.FAST_STABLE_CYC(STB)) DUT (
    .REF_CLK(ref_clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_rq),
    .POWERUP_OSC_CFG(cfg), .CLOCK_OUT_PIN_CFG(co_cfg), .POWERUP_TIMER_EN(pwt),
    .WATCHDOG_TIMER_EN(wdt), .CRYSTAL_OSC_EN(xen), .FAST_OSC_IN(f_in), .SLOW_OSC_IN(s_in),
    .CRYSTAL_OSC_IN(x_in), .EXT_CLOCK_IN(e_in), .GPIO_CLOCK_OUTPUT_PIN_DATA(gdat),
    .GPIO_CLOCK_OUTPUT_PIN_OE_N(goe_n), .FAST_OSC_EN(f_en), .SLOW_OSC_EN(s_en), .SYS_CLK(sys_clk),
    .EXT_CLOCK_PIN_GPIO(pin_gpio), .CLOCK_OUTPUT_PIN_O(co_o), .CLOCK_OUTPUT_PIN_OE_N(co_oe_n)
  );

  osc_partner #(.FAST_HALF(FH), .SLOW_HALF(SH), .XTAL_HALF(XH), .EXT_HALF(EH)) P (
    .clk(ref_clk), .fast_en(f_en), .slow_en(s_en), .xtal_en(xen),
    .fast_o(f_in), .slow_o(s_in), .xtal_o(x_in), .ext_o(e_in)
  );

  // 250 MHz reference
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task tmo();
    errors++;
    $display("mismatch wait expected done seen timeout");
    summarize();
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b,
           output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    adr <= a;
    wdat <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (wait_rq === 1'h0) break;
    end
    if (n == 20) tmo();
    q = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask

  // Status is frozen mid-switch, so a set bit also marks the switch as done
  task poll(input logic [31:0] m, input int lim, output logic [31:0] q);
    int n;
    for (n = 0; n < lim; n++) begin
      bus(1'h0, 4'h4, 32'h0, 4'hF, q);
      if ((q & m) === m) break;
    end
    if (n == lim) tmo();
  endtask

  task lvl(input logic v, inout int c);
    int n;
    for (n = 0; n < 8000; n++) begin
      @(posedge ref_clk);
      c++;
      if (sys_clk === v) break;
    end
    if (n == 8000) tmo();
  endtask

  // Rise-to-rise period of the switched clock, in reference cycles
  task period(output int p);
    int c;
    c = 0;
    lvl(1'h0, c);
    lvl(1'h1, c);
    c = 0;
    lvl(1'h0, c);
    lvl(1'h1, c);
    p = c;
  endtask

  // Expected period per frequency code: slow source direct, else fast with postscaler
  function automatic int per_of(input logic [3:0] c);
    if (c[3:1] == 3'h0) return 2 * SH;
    if (c[3:1] == 3'h1) return (2 * FH) << 9;
    return c[3] ? (2 * FH) << (15 - c) : (2 * FH) << (12 - c);
  endfunction

  // Hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    tmo();
  end

  initial begin
    logic [31:0] q;
    logic [31:0] v;
    int p;
    int off;
    logic [3:0] c;
    void'($urandom(71181));
    repeat (5) @(posedge ref_clk);
    rst <= 1'h0;
    // Start-up from internal block at the default 500 kHz
    poll(32'h10, 400, q);
    chk("status", 32'h90, q & 32'hFFFFFFFE);
    bus(1'h0, 4'h0, 32'h0, 4'hF, q);
    chk("control", 32'h38, q);
    period(p);
    chk("sys period", per_of(4'h7), p);
    chk("ext_clock_in_pin gpio", 32'h1, pin_gpio);
    chk("clock_output_pin oe_n", 32'h0, co_oe_n);
    // Ignored writes: lane 0 disabled, unmapped place
    bus(1'h1, 4'h0, 32'hFFFFFFFF, 4'hE, q);
    bus(1'h1, 4'h8, 32'hFFFFFFFF, 4'hF, q);
    bus(1'h0, 4'h8, 32'h0, 4'hF, q);
    chk("unmapped", 32'h0, q);
    bus(1'h0, 4'h0, 32'h0, 4'hF, q);
    chk("control", 32'h38, q);
    // Slow source, then fast from cold: ready comes before stable
    bus(1'h1, 4'h0, 32'h2, 4'hF, q);
    poll(32'h2, 400, q);
    chk("slow en", 32'h1, s_en);
    period(p);
    chk("slow period", per_of(4'h0), p);
    bus(1'h0, 4'h4, 32'h0, 4'hF, q);
    chk("fast ready off", 32'h0, q[4]);
    bus(1'h1, 4'h0, 32'h7A, 4'hF, q);
    poll(32'h10, 400, q);
    chk("stable early", 32'h0, q[0]);
    repeat (STB) @(posedge ref_clk);
    bus(1'h0, 4'h4, 32'h0, 4'hF, q);
    chk("stable late", 32'h1, q[0]);
    // Either timer enable forces the slow source on
    for (int i = 0; i < 2; i++) begin
      pwt <= (i == 0);
      wdt <= (i == 1);
      repeat (4) @(posedge ref_clk);
      chk("slow en timer", 32'h1, s_en);
    end
    pwt <= 1'h0;
    wdt <= 1'h0;
    repeat (4) @(posedge ref_clk);
    chk("slow en idle", 32'h0, s_en);
    // Every frequency code in turn from a random start, with a random 1x source code
    off = $urandom % 16;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i + off);
      v = {25'h0, c, 1'h0, 1'h1, 1'($urandom)};
      gdat <= 1'($urandom);
      bus(1'h1, 4'h0, v, 4'hF, q);
      bus(1'h0, 4'h0, 32'h0, 4'hF, q);
      chk("control", v, q);
      // A cold start keeps the old clock running, so wait for the flag that ends the switch
      poll((c[3:1] == 3'h0) ? 32'h2 : 32'h10, 2000, q);
      period(p);
      chk("sys period", per_of(c), p);
      chk("fast en", 32'(c[3:1] != 3'h0), f_en);
      chk("slow en", 32'(c[3:1] == 3'h0), s_en);
    end
    // Crystal: software waits for ready, hardware still waits 1024 cycles
    xen <= 1'h1;
    bus(1'h0, 4'h4, 32'h0, 4'hF, q);
    chk("xtal not ready", 32'h0, q[7]);
    poll(32'h80, 6000, q);
    bus(1'h1, 4'h0, 32'h39, 4'hF, q);
    repeat (1024 * 2 * XH) @(posedge ref_clk);
    period(p);
    period(p);
    chk("xtal period", 2 * XH, p);
    bus(1'h0, 4'h4, 32'h0, 4'hF, q);
    chk("on ext", 32'h0, q[5]);
    // Second reset: random external config 01, 10 or 11, clock pin handed to port logic
    rst <= 1'h1;
    cfg <= 2'h1 + 2'($urandom % 3);
    co_cfg <= 1'h0;
    xen <= 1'h0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'h0;
    bus(1'h0, 4'h0, 32'h0, 4'hF, q);
    chk("control", 32'h38, q);
    period(p);
    chk("ext period", 2 * EH, p);
    bus(1'h0, 4'h4, 32'h0, 4'hF, q);
    chk("on ext", 32'h1, q[5]);
    chk("ext_clock_in_pin gpio", 32'h0, pin_gpio);
    chk("fast en cfg", 32'(cfg == 2'h3), f_en);
    // Slow setting with source 00 leaves the clock alone but may wake the slow source
    bus(1'h1, 4'h0, 32'h0, 4'hF, q);
    repeat (4) @(posedge ref_clk);
    chk("slow en cfg", 32'(cfg == 2'h1), s_en);
    for (int i = 0; i < 4; i++) begin
      gdat <= 1'($urandom);
      goe_n <= 1'($urandom);
      repeat (3) @(posedge ref_clk);
      chk("pin data", gdat, co_o);
      chk("pin oe_n", goe_n, co_oe_n);
    end
    summarize();
  end
endmodule
